// *** hw/spmp_port.sv ***
// byte-wide master/slave synchronous serial port with control, status and data registers
`timescale 1ns/10ps
`default_nettype none
module spmp_port
  import spmp_pkg::*;
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  output logic            O_IRQ,
  input  wire logic       I_SCK,
  output logic            O_SCK,
  output logic            O_SCK_OE_N,
  input  wire logic       I_MOSI,
  output logic            O_MOSI,
  output logic            O_MOSI_OE_N,
  input  wire logic       I_MISO,
  output logic            O_MISO,
  output logic            O_MISO_OE_N,
  input  wire logic       I_SS_N,
  output logic            O_PIN_FUNC
);
  typedef struct packed {
    logic [7:0]     ctrl;
    logic           done;
    logic           write_collision_flag;
    logic           mode_fault_flag;
    logic           sr_seen;     // status accessed while done was set
    logic           write_collision_flag_seen;   // status accessed while collision was set
    logic           mode_fault_flag_seen;   // status accessed while fault was set
    logic [7:0]     shift;
    logic [7:0]     rx_buf;
    logic [3:0]     edges;       // clock edges seen in this byte
    logic           busy;
    logic           sck;
    logic           out_bit;
    spmp_state_type state;
    logic [7:0]     rdata;
    logic           irq;
    logic           sck_oe_n;
    logic           mosi_oe_n;
    logic           miso_oe_n;
  } spmp_port_type;

  spmp_port_type st_reg;
  spmp_port_type st_next;

  logic       tick_w;
  logic       sck_lvl_w;
  logic       sck_rise_w;
  logic       sck_fall_w;
  logic       master_w;
  logic       enable_w;
  logic       idle_w;
  logic       phase_w;
  logic [2:0] rate_w;
  logic       rd_data_w;
  logic       wr_data_w;
  logic       wr_ctrl_w;
  logic       acc_stat_w;
  logic       in_bit_w;

  assign master_w = st_reg.ctrl[SPMP_CR_MASTER];
  assign enable_w = st_reg.ctrl[SPMP_CR_PIN_EN];
  assign idle_w   = st_reg.ctrl[SPMP_CR_IDLE];
  assign phase_w  = st_reg.ctrl[SPMP_CR_PHASE];
  assign rate_w   = {st_reg.ctrl[SPMP_CR_RATE_HI], st_reg.ctrl[SPMP_CR_RATE_LO +: 2]};

  // register port decode
  // a status write stores nothing but still counts as a status access
  assign rd_data_w  = I_RD && (I_ADDR == SPMP_ADDR_DATA);
  assign wr_data_w  = I_WR && (I_ADDR == SPMP_ADDR_DATA);
  assign wr_ctrl_w  = I_WR && (I_ADDR == SPMP_ADDR_CTRL);
  assign acc_stat_w = (I_RD || I_WR) && (I_ADDR == SPMP_ADDR_STATUS);

  // data in comes from the opposite pin in each mode
  assign in_bit_w = master_w ? I_MISO : I_MOSI;

  // serial clock half periods only while a master byte runs
  spmp_clkdiv u_div (
    .i_clk  (I_SYS_CLK),
    .i_rst  (I_RST),
    .i_run  ((st_reg.state == SPMP_SHIFT) && master_w),
    .i_rate (rate_w),
    .o_tick (tick_w)
  );

  // external clock edges for slave mode
  spmp_edge u_sck (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_sig   (I_SCK),
    .o_level (sck_lvl_w),
    .o_rise  (sck_rise_w),
    .o_fall  (sck_fall_w)
  );

  // main port state update
  always_comb begin
    logic ev_edge;
    logic leading;
    logic capture;
    logic [3:0] edges_n;
    logic [7:0] cw;
    ev_edge = 1'b0;
    leading = 1'b0;
    capture = 1'b0;
    edges_n = '0;
    cw      = I_WDATA;
    st_next = st_reg;

    // control write: fault blocks setting enable and master outside the clearing step
    if (wr_ctrl_w) begin
      if (st_reg.mode_fault_flag && !st_reg.mode_fault_flag_seen) begin
        cw[SPMP_CR_PIN_EN] = 1'b0;
        cw[SPMP_CR_MASTER] = 1'b0;
      end
      st_next.ctrl = cw;
      if (st_reg.mode_fault_flag_seen) begin
        st_next.mode_fault_flag      = 1'b0;
        st_next.mode_fault_flag_seen = 1'b0;
      end
    end

    // status access arms the clearing sequences
    if (acc_stat_w) begin
      st_next.sr_seen   = st_reg.done;
      st_next.write_collision_flag_seen = st_reg.write_collision_flag;
      if (st_reg.mode_fault_flag) begin
        st_next.mode_fault_flag_seen = 1'b1;
      end
    end

    // data access completes done and collision clearing
    if ((rd_data_w || wr_data_w) && st_reg.sr_seen) begin
      st_next.done    = 1'b0;
      st_next.sr_seen = 1'b0;
    end
    if ((rd_data_w || wr_data_w) && st_reg.write_collision_flag_seen) begin
      st_next.write_collision_flag      = 1'b0;
      st_next.write_collision_flag_seen = 1'b0;
    end

    // data write: ignored while done, collides while busy, else loads shifter
    // an enabled slave with select low has its shifter frozen, so the write collides
    if (wr_data_w && !st_reg.done) begin
      if (st_reg.busy || (!master_w && !I_SS_N && enable_w)) begin
        st_next.write_collision_flag = 1'b1;
      end else begin
        st_next.shift   = I_WDATA;
        st_next.out_bit = I_WDATA[SPMP_BITS-1];
        st_next.edges   = '0;
        if (master_w && enable_w) begin
          st_next.busy = 1'b1;
        end
      end
    end

    // clock edge for this cycle
    if (enable_w && master_w && st_reg.busy && tick_w) begin
      ev_edge     = 1'b1;
      st_next.sck = ~st_reg.sck;
    end else if (enable_w && !master_w && !I_SS_N && (sck_rise_w || sck_fall_w)) begin
      ev_edge = 1'b1;
    end
    // slave stays busy from its first edge until the byte ends or select rises
    if (!master_w) begin
      st_next.busy = !I_SS_N && enable_w && (st_reg.edges != 4'h0);
    end

    // leading edge leaves idle level; capture on first or second transition
    if (ev_edge) begin
      leading = master_w ? (st_reg.sck == idle_w) : (sck_lvl_w == idle_w);
      capture = (leading != phase_w);
      edges_n = st_reg.edges + 4'h1;
      st_next.edges = edges_n;
      if (!master_w) begin
        st_next.busy = 1'b1;
      end
      if (capture) begin
        st_next.shift = {st_reg.shift[SPMP_BITS-2:0], in_bit_w};
      end else if (phase_w || st_reg.edges != 4'h0) begin
        st_next.out_bit = st_reg.shift[SPMP_BITS-1];
      end
      if (st_reg.edges == 4'(2 * SPMP_BITS - 1)) begin
        st_next.done   = 1'b1;
        // on phase 0 the last edge only launches, so the shifter already holds the byte
        st_next.rx_buf = st_next.shift;
        st_next.busy   = 1'b0;
        st_next.edges  = '0;
        st_next.sck    = idle_w;
      end
    end
    if (!master_w && I_SS_N) begin
      st_next.edges = '0; // slave byte restarts on each select
    end
    if (!st_reg.busy && master_w) begin
      st_next.sck = idle_w;
    end

    // fault: select low in master mode drops enable and master
    // the fault is raised once: dropping master ends the condition from the next cycle on
    if (master_w && enable_w && !I_SS_N) begin
      st_next.mode_fault_flag                   = 1'b1;
      st_next.ctrl[SPMP_CR_PIN_EN]   = 1'b0;
      st_next.ctrl[SPMP_CR_MASTER]   = 1'b0;
      st_next.busy                   = 1'b0;
      st_next.edges                  = '0;
    end

    // sequencer state: shift while a byte runs, idle otherwise
    unique case (st_reg.state)
      SPMP_IDLE: begin
        if (st_next.busy) begin
          st_next.state = SPMP_SHIFT;
        end
      end
      SPMP_SHIFT: begin
        if (!st_next.busy) begin
          st_next.state = SPMP_IDLE;
        end
      end
      default: begin
        st_next.state = SPMP_IDLE; // unused codes fall back to idle
      end
    endcase

    // read data one cycle later; reads have no side effect beyond flag sequences
    st_next.rdata = 8'h00;
    if (I_RD) begin
      unique case (I_ADDR)
        SPMP_ADDR_DATA:   st_next.rdata = st_reg.rx_buf;
        SPMP_ADDR_CTRL:   st_next.rdata = st_reg.ctrl;
        SPMP_ADDR_STATUS: begin
          st_next.rdata[SPMP_SR_DONE] = st_reg.done;
          st_next.rdata[SPMP_SR_WRITE_COLLISION_FLAG] = st_reg.write_collision_flag;
          st_next.rdata[SPMP_SR_MODE_FAULT_FLAG] = st_reg.mode_fault_flag;
        end
        default:          st_next.rdata = 8'h00;
      endcase
    end

    // interrupt from done or fault only, collision excluded
    st_next.irq = st_next.ctrl[SPMP_CR_IRQ_EN] && (st_next.done || st_next.mode_fault_flag);

    // pin directions; enables are active low
    st_next.sck_oe_n  = !(st_next.ctrl[SPMP_CR_PIN_EN] && st_next.ctrl[SPMP_CR_MASTER]);
    st_next.mosi_oe_n = !(st_next.ctrl[SPMP_CR_PIN_EN] && st_next.ctrl[SPMP_CR_MASTER]);
    st_next.miso_oe_n = !(st_next.ctrl[SPMP_CR_PIN_EN] && !st_next.ctrl[SPMP_CR_MASTER]
                          && !I_SS_N);
  end

  // low control nibble is documented as unknown; zero keeps simulation clean
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg       <= '0;
      st_reg.ctrl  <= SPMP_CTRL_RST;
      st_reg.state <= SPMP_IDLE;
      st_reg.sck_oe_n  <= 1'b1;
      st_reg.mosi_oe_n <= 1'b1;
      st_reg.miso_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_RDATA     = st_reg.rdata;
  assign O_IRQ       = st_reg.irq;
  assign O_SCK       = st_reg.sck;
  assign O_SCK_OE_N  = st_reg.sck_oe_n;
  assign O_MOSI      = st_reg.out_bit;
  assign O_MOSI_OE_N = st_reg.mosi_oe_n;
  assign O_MISO      = st_reg.out_bit;
  assign O_MISO_OE_N = st_reg.miso_oe_n;
  assign O_PIN_FUNC  = st_reg.ctrl[SPMP_CR_PIN_EN];
endmodule : spmp_port
`default_nettype wire

// *** hw/spmp_pkg.sv ***
// package of register map, field positions and timing constants for the serial port
package spmp_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] SPMP_ADDR_DATA   = 8'h21;
  localparam logic [7:0] SPMP_ADDR_CTRL   = 8'h22;
  localparam logic [7:0] SPMP_ADDR_STATUS = 8'h23;
  // control register field positions
  localparam int SPMP_CR_IRQ_EN  = 7;
  localparam int SPMP_CR_PIN_EN  = 6;
  localparam int SPMP_CR_RATE_HI = 5;
  localparam int SPMP_CR_MASTER  = 4;
  localparam int SPMP_CR_IDLE    = 3;
  localparam int SPMP_CR_PHASE   = 2;
  localparam int SPMP_CR_RATE_LO = 0;
  // status register field positions
  localparam int SPMP_SR_DONE  = 7;
  localparam int SPMP_SR_WRITE_COLLISION_FLAG  = 6;
  localparam int SPMP_SR_MODE_FAULT_FLAG  = 4;
  // reset values
  localparam logic [7:0] SPMP_CTRL_RST   = 8'h00;
  localparam logic [7:0] SPMP_STATUS_RST = 8'h00;
  // byte length and half-period counter width
  localparam int SPMP_BITS     = 8;
  localparam int SPMP_DIV_W    = 7;
  // rate codes {high, low[1:0]} mapped to full serial clock periods in cpu clocks
  localparam logic [2:0] SPMP_RATE_4   = 3'h4;
  localparam logic [2:0] SPMP_RATE_8   = 3'h0;
  localparam logic [2:0] SPMP_RATE_16  = 3'h1;
  localparam logic [2:0] SPMP_RATE_32  = 3'h6;
  localparam logic [2:0] SPMP_RATE_64  = 3'h2;
  localparam logic [2:0] SPMP_RATE_128 = 3'h3;
  localparam int SPMP_DIV_4   = 4;
  localparam int SPMP_DIV_8   = 8;
  localparam int SPMP_DIV_16  = 16;
  localparam int SPMP_DIV_32  = 32;
  localparam int SPMP_DIV_64  = 64;
  localparam int SPMP_DIV_128 = 128;
  // transfer states, entered for master and slave bytes alike
  typedef enum logic [1:0] {
    SPMP_IDLE  = 2'b00,
    SPMP_SHIFT = 2'b01
  } spmp_state_type;
endpackage : spmp_pkg

// *** hw/spmp_clkdiv.sv ***
// serial clock divider: one-cycle pulse each half period of the chosen rate
`timescale 1ns/10ps
`default_nettype none
module spmp_clkdiv
  import spmp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [2:0] i_rate,
  output logic            o_tick
);
  typedef struct packed {
    logic [SPMP_DIV_W-1:0] cnt;
    logic                  tick;
  } spmp_div_type;

  spmp_div_type div_reg;
  spmp_div_type div_next;
  logic [SPMP_DIV_W-1:0] half_w;

  // half period from the six legal codes; the two unused codes fall back to the slowest
  always_comb begin
    unique case (i_rate)
      SPMP_RATE_4:   half_w = SPMP_DIV_W'(SPMP_DIV_4 / 2);
      SPMP_RATE_8:   half_w = SPMP_DIV_W'(SPMP_DIV_8 / 2);
      SPMP_RATE_16:  half_w = SPMP_DIV_W'(SPMP_DIV_16 / 2);
      SPMP_RATE_32:  half_w = SPMP_DIV_W'(SPMP_DIV_32 / 2);
      SPMP_RATE_64:  half_w = SPMP_DIV_W'(SPMP_DIV_64 / 2);
      SPMP_RATE_128: half_w = SPMP_DIV_W'(SPMP_DIV_128 / 2);
      default:       half_w = SPMP_DIV_W'(SPMP_DIV_128 / 2);
    endcase
  end

  // counter restarts whenever no transfer runs so the first half period is full
  always_comb begin
    div_next      = div_reg;
    div_next.tick = 1'b0;
    if (!i_run) begin
      div_next.cnt = '0;
    end else if (div_reg.cnt == half_w - SPMP_DIV_W'(1)) begin
      div_next.cnt  = '0;
      div_next.tick = 1'b1;
    end else begin
      div_next.cnt = div_reg.cnt + SPMP_DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign o_tick = div_reg.tick;
endmodule : spmp_clkdiv
`default_nettype wire

// *** hw/spmp_edge.sv ***
// edge detector on a synchronous pin input
`timescale 1ns/10ps
`default_nettype none
module spmp_edge (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_sig,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  typedef struct packed {
    logic last;
  } spmp_edge_type;

  spmp_edge_type edge_reg;
  spmp_edge_type edge_next;

  // remember the previous sample
  always_comb begin
    edge_next      = edge_reg;
    edge_next.last = i_sig;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= edge_next;
    end
  end

  assign o_level = edge_reg.last;
  assign o_rise  = i_sig & ~edge_reg.last;
  assign o_fall  = ~i_sig & edge_reg.last;
endmodule : spmp_edge
`default_nettype wire

// *** dv/spmp_port_chk.sv ***
// pin and register port checks for the serial port
`timescale 1ns/10ps
`default_nettype none
module spmp_port_chk
  import spmp_pkg::*;
(
  input wire logic       I_SYS_CLK,
  input wire logic       I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic       I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic       O_SCK,
  input wire logic       O_SCK_OE_N,
  input wire logic       O_MOSI_OE_N,
  input wire logic       O_MISO_OE_N,
  input wire logic       I_SS_N,
  input wire logic       O_PIN_FUNC
);
  // one domain; checks sleep through reset
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // read data live only in the cycle after a read
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read cycle");
  a_status_unused: assert property ($past(I_RD) && $past(I_ADDR) == SPMP_ADDR_STATUS |->
    O_RDATA[5] == 1'b0 && O_RDATA[3:0] == 4'h0) else $error("unused status bit set");
  // clock drive needs the pin function
  a_clk_needs_func: assert property (!O_SCK_OE_N |-> O_PIN_FUNC || $past(O_PIN_FUNC))
    else $error("clock driven without pin function");
  a_data_dir: assert property (!O_MOSI_OE_N |-> O_MISO_OE_N)
    else $error("both data pins driven");
  // low select while mastering drops the pins quickly
  a_fault_drop: assert property (!O_SCK_OE_N && !I_SS_N |-> ##[1:4] !O_PIN_FUNC)
    else $error("mode fault kept pin function");
  a_pins_free: assert property (!O_PIN_FUNC && !$past(O_PIN_FUNC) |->
    O_SCK_OE_N && O_MOSI_OE_N && O_MISO_OE_N) else $error("pins driven while released");
  // a deselected slave lets go of its data pin
  a_slave_quiet: assert property (I_SS_N [*4] |-> O_MISO_OE_N)
    else $error("data pin driven while deselected");
  // shortest half period is two cycles
  a_half_min: assert property ($changed(O_SCK) && !O_SCK_OE_N && !$past(O_SCK_OE_N) |=>
    $stable(O_SCK)) else $error("clock half period too short");
endmodule : spmp_port_chk
bind spmp_port spmp_port_chk u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_SCK(O_SCK), .O_SCK_OE_N(O_SCK_OE_N), .O_MOSI_OE_N(O_MOSI_OE_N),
  .O_MISO_OE_N(O_MISO_OE_N), .I_SS_N(I_SS_N), .O_PIN_FUNC(O_PIN_FUNC)
);
`default_nettype wire

// *** dv/spmp_far_end.sv ***
// far end model: slave to a mastering port, master to a slave port
`timescale 1ns/10ps
`default_nettype none
module spmp_far_end (
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  input  wire logic i_miso_oe_n,
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_miso,
  output logic      o_ss_n
);
  logic [7:0] tx_s;
  logic [7:0] rx_s;
  logic       ph_s;
  int         edges;
  // an undriven data line never reads as data
  wire        miso_w = i_miso_oe_n ? ~i_miso : i_miso;
  assign o_miso = tx_s[7];
  // deselected and quiet at start
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_ss_n = 1'b1;
    tx_s = 8'h00;
    ph_s = 1'b0;
  end
  // load reply byte; edge count restarts so mode changes are not counted
  task automatic arm(input logic [7:0] b, input logic ph);
    tx_s = b;
    ph_s = ph;
    edges = 0;
  endtask : arm
  // select moves off the clock edge so the port never races it
  task automatic sel(input logic v);
    #2;
    o_ss_n = v;
  endtask : sel
  // slave side: capture on the chosen edge, shift on the other
  always @(i_sck) begin
    edges = edges + 1;
    if (ph_s ? !edges[0] : edges[0]) begin
      rx_s = {rx_s[6:0], i_mosi};
    end else if (edges > 1) begin
      tx_s = {tx_s[6:0], ~tx_s[7]};
    end
  end
  // stray clocks with select high, started off the clock edge
  task automatic noise();
    #3;
    repeat (6) begin
      o_sck = ~o_sck;
      #40;
    end
  endtask : noise
  // master side: sixteen edges, select raised after each byte
  task automatic xfer(input logic [7:0] b, input logic pol, input logic ph,
                      output logic [7:0] r);
    logic [7:0] sh;
    sh = b;
    r = 8'h00;
    // whole clock periods only, so pins keep the offset from the edge that noise set
    o_sck = pol;
    #56;
    o_ss_n = 1'b0;
    o_mosi = sh[7];
    #104;
    for (int k = 0; k < 16; k++) begin
      o_sck = ~o_sck;
      if (ph ? k[0] : !k[0]) begin
        r = {r[6:0], miso_w};
      end else if (k > 0) begin
        sh = {sh[6:0], ~sh[7]};
        o_mosi = sh[7];
      end
      #80;
    end
    #104;
    o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask : xfer
endmodule : spmp_far_end
`default_nettype wire

// *** dv/spi_master_slave_port_test.sv ***
// self-checking bench: registers, master rates, mode fault, slave modes
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port_test
  import spmp_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] txb;
  logic [7:0] rxb;
  logic [7:0] got;
  logic [7:0] ctrl;
  logic [7:0] exp_q[$];
  wire logic  irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, pin_func;
  wire logic  sck_f, mosi_f, miso_f, ss_n_f;
  int         err_count, check_count, i, n, t0;
  int         cyc = 0;
  logic [2:0] codes[6] = '{SPMP_RATE_4, SPMP_RATE_8, SPMP_RATE_16, SPMP_RATE_32,
                           SPMP_RATE_64, SPMP_RATE_128};
  int         divs[6] = '{SPMP_DIV_4, SPMP_DIV_8, SPMP_DIV_16, SPMP_DIV_32, SPMP_DIV_64,
                          SPMP_DIV_128};
  spmp_port DUT (
    .I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_IRQ(irq), .I_SCK(sck_f), .O_SCK(sck_o), .O_SCK_OE_N(sck_oe_n),
    .I_MOSI(mosi_f), .O_MOSI(mosi_o), .O_MOSI_OE_N(mosi_oe_n), .I_MISO(miso_f),
    .O_MISO(miso_o), .O_MISO_OE_N(miso_oe_n), .I_SS_N(ss_n_f), .O_PIN_FUNC(pin_func)
  );
  spmp_far_end far (
    .i_sck(sck_o), .i_mosi(mosi_o), .i_miso(miso_o), .i_miso_oe_n(miso_oe_n),
    .o_sck(sck_f), .o_mosi(mosi_f), .o_miso(miso_f), .o_ss_n(ss_n_f)
  );
  // 125 MHz clock and a cycle count for transfer lengths
  initial begin
    clk = 1'b0;
    forever begin
      #4 clk = ~clk;
    end
  end
  always @(posedge clk) cyc <= cyc + 1;
  // register port cycles; read data taken in the cycle after the strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask : rchk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // bounded wait; a hang ends the run as a failure
  task automatic wait_irq(input int lim);
    int w;
    w = 0;
    while (irq !== 1'b1 && w < lim) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (irq !== 1'b1) begin
      err_count++;
      $display("MISMATCH irq_wait expected 1 seen 0");
      end_sim();
    end
  endtask : wait_irq
  // main sequence
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    err_count = 0;
    check_count = 0;
    void'($urandom(28));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl_rst", SPMP_ADDR_CTRL, SPMP_CTRL_RST);
    rchk("stat_rst", SPMP_ADDR_STATUS, SPMP_STATUS_RST);
    wr_reg(SPMP_ADDR_STATUS, 8'hFF);
    rchk("stat_ro", SPMP_ADDR_STATUS, 8'h00);
    rchk("unmapped", 8'h30, 8'h00);
    // master at every rate, idle level and phase; one collision mid-byte
    for (i = 0; i < 6; i++) begin
      txb = 8'($urandom());
      rxb = 8'($urandom());
      ctrl = {2'b11, codes[i][2], 1'b1, i[0], i[1], codes[i][1:0]};
      wr_reg(SPMP_ADDR_CTRL, ctrl);
      repeat (3) @(posedge clk);
      chk("sck_idle", {7'h00, i[0]}, {7'h00, sck_o});
      far.arm(rxb, i[1]);
      wr_reg(SPMP_ADDR_DATA, txb);
      t0 = cyc;
      if (i == 2) begin
        repeat (20) @(posedge clk);
        wr_reg(SPMP_ADDR_DATA, ~txb);
      end
      wait_irq(8 * divs[i] + 20);
      n = cyc - t0;
      chk("xfer_len", 8'h01, {7'h00, n >= 8 * divs[i] - 2 && n <= 8 * divs[i] + 6});
      chk("far_rx", txb, far.rx_s);
      wr_reg(SPMP_ADDR_DATA, 8'hA5);
      repeat (70) @(posedge clk);
      chk("edges", 8'h10, 8'(far.edges));
      exp_q.push_back(rxb);
      rchk("rx_nostat", SPMP_ADDR_DATA, exp_q[0]);
      rchk("done_held", SPMP_ADDR_STATUS, i == 2 ? 8'hC0 : 8'h80);
      rchk("rx_buf", SPMP_ADDR_DATA, exp_q.pop_front());
      rchk("stat_clr", SPMP_ADDR_STATUS, 8'h00);
      chk("irq_clr", 8'h00, {7'h00, irq});
    end
    // mode fault while mastering, then the clearing sequence
    wr_reg(SPMP_ADDR_CTRL, 8'hD8);
    repeat (3) @(posedge clk);
    far.sel(1'b0);
    repeat (8) @(posedge clk);
    #1;
    chk("func_drop", 8'h00, {7'h00, pin_func});
    chk("irq_fault", 8'h01, {7'h00, irq});
    rchk("ctrl_fault", SPMP_ADDR_CTRL, 8'h88);
    far.sel(1'b1);
    repeat (4) @(posedge clk);
    wr_reg(SPMP_ADDR_CTRL, 8'hD8);
    rchk("ctrl_block", SPMP_ADDR_CTRL, 8'h88);
    rchk("stat_fault", SPMP_ADDR_STATUS, 8'h10);
    wr_reg(SPMP_ADDR_CTRL, 8'hD8);
    rchk("stat_fclr", SPMP_ADDR_STATUS, 8'h00);
    rchk("ctrl_back", SPMP_ADDR_CTRL, 8'hD8);
    // slave in all four clock modes, random rate bits, stray clocks first
    for (i = 0; i < 4; i++) begin
      txb = 8'($urandom());
      rxb = 8'($urandom());
      ctrl = {2'b01, 1'($urandom()), 1'b0, i[0], i[1], 2'($urandom())};
      wr_reg(SPMP_ADDR_CTRL, ctrl);
      wr_reg(SPMP_ADDR_DATA, txb);
      far.noise();
      far.xfer(rxb, i[0], i[1], got);
      exp_q.push_back(rxb);
      repeat (4) @(posedge clk);
      chk("miso", txb, got);
      chk("irq_off", 8'h00, {7'h00, irq});
      rchk("slv_done", SPMP_ADDR_STATUS, 8'h80);
      rchk("slv_rx", SPMP_ADDR_DATA, exp_q.pop_front());
    end
    // selected slave with interrupt enabled: a data write collides and stays silent
    wr_reg(SPMP_ADDR_CTRL, 8'hC0);
    far.sel(1'b0);
    wr_reg(SPMP_ADDR_DATA, 8'h3C);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_write_collision_flag", 8'h00, {7'h00, irq});
    rchk("slv_write_collision_flag", SPMP_ADDR_STATUS, 8'h40);
    far.sel(1'b1);
    end_sim();
  end
endmodule : spi_master_slave_port_test
`default_nettype wire
